// >>> service_request_pkg.sv
/*
 * Shared constants for the service request configuration block and its
 * host strobe decoder.
 * Assumes host bus inputs are already synchronous to clock_in.
 */
package service_request_pkg;
	localparam int ADDR_W = 7;
	localparam logic [6:0] CONFIG_OFFSET = 7'h66;
	localparam logic [6:0] REVISION_OFFSET = 7'h6B;
	// default acknowledge addresses, overridable at the top level
	localparam logic [6:0] MODEM_ACK_OFFSET = 7'h75;
	localparam logic [6:0] TX_ACK_OFFSET = 7'h76;
	localparam logic [6:0] RX_ACK_OFFSET = 7'h77;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] REVISION_RESET = 8'h5A; // arbitrary revision value
	localparam logic PACKAGE_TYPE_RESET = 1'b0;
	localparam int PKG_BIT = 7;
	localparam int REGACK_BIT = 6;
	localparam int CHAIN_BIT = 5;
	localparam int GLOBAL_PRI_BIT = 4;
	localparam int FAIR_OVERRIDE_BIT = 3;
	localparam int AUTO_PRI_BIT = 1;
	localparam int ORDER_SEL_BIT = 0;
	localparam logic [1:0] LEVEL_NONE = 2'h0;
	localparam logic [1:0] LEVEL_MODEM = 2'h1;
	localparam logic [1:0] LEVEL_TX = 2'h2;
	localparam logic [1:0] LEVEL_RX = 2'h3;
	localparam logic [2:0] MOD_NONE = 3'h0;
endpackage : service_request_pkg

// >>> host_strobe.sv
/*
 * Host strobe decoder: one pulse per read or write access, plus the
 * acknowledge type of the address being read.
 * Assumes chip select and strobes are synchronous, active low.
 */
`timescale 1ns/100ps
module host_strobe #(
	parameter logic [6:0] MODEM_ACK_ADDR = service_request_pkg::MODEM_ACK_OFFSET,
	parameter logic [6:0] TX_ACK_ADDR = service_request_pkg::TX_ACK_OFFSET,
	parameter logic [6:0] RX_ACK_ADDR = service_request_pkg::RX_ACK_OFFSET
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// host strobes
	input wire logic select_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic [6:0] addr_in,
	// decoded
	output logic read_active_out,
	output logic read_start_out,
	output logic write_start_out,
	output logic [1:0] ack_type_out
);
	logic read_act;
	logic write_act;
	logic read_act_q;
	logic write_act_q;

	assign read_act = !select_n_in && !read_n_in;
	assign write_act = !select_n_in && !write_n_in;

	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			read_act_q <= 1'b0;
			write_act_q <= 1'b0;
		end
		else
		begin
			read_act_q <= read_act;
			write_act_q <= write_act;
		end
	end

	// held strobes count once: only the leading edge is an event
	assign read_start_out = read_act && !read_act_q;
	assign write_start_out = write_act && !write_act_q;
	assign read_active_out = read_act;

	always_comb
	begin
		if (addr_in == MODEM_ACK_ADDR)
			ack_type_out = service_request_pkg::LEVEL_MODEM;
		else if (addr_in == TX_ACK_ADDR)
			ack_type_out = service_request_pkg::LEVEL_TX;
		else if (addr_in == RX_ACK_ADDR)
			ack_type_out = service_request_pkg::LEVEL_RX;
		else
			ack_type_out = service_request_pkg::LEVEL_NONE;
	end

	single_start_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		read_active_out && $past(read_active_out) |-> !read_start_out)
		else $error("read start pulsed twice in one access");
endmodule : host_strobe

// >>> service_request_config.sv
/*
 * Global configuration registers and register-based acknowledge logic.
 * Assumes host bus and request inputs are synchronous to clock_in.
 */
`timescale 1ns/100ps
module service_request_config #(
	parameter logic [7:0] REVISION_CODE = service_request_pkg::REVISION_RESET,
	parameter logic PACKAGE_TYPE = service_request_pkg::PACKAGE_TYPE_RESET,
	parameter logic [6:0] MODEM_ACK_ADDR = service_request_pkg::MODEM_ACK_OFFSET,
	parameter logic [6:0] TX_ACK_ADDR = service_request_pkg::TX_ACK_OFFSET,
	parameter logic [6:0] RX_ACK_ADDR = service_request_pkg::RX_ACK_OFFSET
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic soft_reset_in,
	// host parallel bus
	input wire logic select_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic [6:0] addr_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	// service requests and vector
	input wire logic [2:0] pending_req_in,
	input wire logic [2:0] global_req_in,
	input wire logic [7:0] vector_base_in,
	// acknowledge chain
	input wire logic acknowledge_input_n,
	input wire logic [1:0] hw_ack_type_in,
	output logic acknowledge_output_n,
	// acknowledge result
	output logic ack_taken_out,
	output logic [1:0] ack_level_out,
	// priority and fairness controls
	input wire logic [2:0] fair_bits_in,
	output logic [2:0] fair_bits_out,
	output logic automatic_priority_enable,
	output logic priority_order_select,
	output logic global_priority_select
);
	logic read_active;
	logic read_start;
	logic write_start;
	logic [1:0] ack_type;
	logic [7:0] config_q;
	logic [7:0] revision_q;
	logic [7:0] data_q;
	logic ack_taken_q;
	logic [1:0] ack_level_q;
	logic chain_q;
	logic hw_ack_q;
	logic hw_ack_start;
	logic reg_ack;
	logic [1:0] reg_level;
	logic [1:0] hw_level;
	logic register_ack_enable;
	logic register_ack_chain_enable;
	logic fairness_override;

	host_strobe #(
		.MODEM_ACK_ADDR(MODEM_ACK_ADDR),
		.TX_ACK_ADDR(TX_ACK_ADDR),
		.RX_ACK_ADDR(RX_ACK_ADDR)
	) strobe_u (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.select_n_in(select_n_in),
		.read_n_in(read_n_in),
		.write_n_in(write_n_in),
		.addr_in(addr_in),
		.read_active_out(read_active),
		.read_start_out(read_start),
		.write_start_out(write_start),
		.ack_type_out(ack_type)
	);

	assign register_ack_enable = config_q[service_request_pkg::REGACK_BIT];
	assign register_ack_chain_enable = config_q[service_request_pkg::CHAIN_BIT];
	assign fairness_override = config_q[service_request_pkg::FAIR_OVERRIDE_BIT];
	assign automatic_priority_enable = config_q[service_request_pkg::AUTO_PRI_BIT];
	assign priority_order_select = config_q[service_request_pkg::ORDER_SEL_BIT];
	assign global_priority_select = config_q[service_request_pkg::GLOBAL_PRI_BIT];
	assign fair_bits_out = fairness_override ? 3'h7 : fair_bits_in;

	// level granted for an acknowledge of a given type; 0 means nothing matched
	function automatic logic [1:0] resolve(input logic [1:0] kind, input logic [2:0] pend,
		input logic [2:0] glob, input logic [7:0] cfg);
		logic [2:0] view;
		logic [1:0] pick;
		view = cfg[service_request_pkg::GLOBAL_PRI_BIT] ? glob : pend;
		pick = service_request_pkg::LEVEL_NONE;
		// only modem-type acknowledges are re-prioritised; tx and rx stay specific
		if (kind == service_request_pkg::LEVEL_MODEM && cfg[service_request_pkg::AUTO_PRI_BIT])
		begin
			if (cfg[service_request_pkg::ORDER_SEL_BIT])
				pick = view[0] ? 2'h1 : view[1] ? 2'h2 : view[2] ? 2'h3 : 2'h0;
			else
				pick = view[2] ? 2'h3 : view[1] ? 2'h2 : view[0] ? 2'h1 : 2'h0;
		end
		else
			pick = kind;
		if (pick == service_request_pkg::LEVEL_NONE || !pend[pick - 2'h1])
			pick = service_request_pkg::LEVEL_NONE;
		resolve = pick;
	endfunction : resolve

	function automatic logic [7:0] modify_vector(input logic [7:0] base, input logic [2:0] code);
		modify_vector = {base[7:3], code};
	endfunction : modify_vector

	assign reg_ack = read_start && register_ack_enable && ack_type != 2'h0;
	assign reg_level = resolve(ack_type, pending_req_in, global_req_in, config_q);
	assign hw_ack_start = !acknowledge_input_n && !hw_ack_q;
	assign hw_level = resolve(hw_ack_type_in, pending_req_in, global_req_in, config_q);

	// configuration register: bit 7 is not stored, reserved bit kept as written
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			config_q <= service_request_pkg::CONFIG_RESET;
		else if (soft_reset_in)
			config_q <= service_request_pkg::CONFIG_RESET;
		else if (write_start && addr_in == service_request_pkg::CONFIG_OFFSET)
			config_q <= {1'b0, data_in[6:0]};
	end

	// revision storage: reset to REVISION_CODE, host-writable, read back at REVISION_OFFSET
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			revision_q <= REVISION_CODE;
		else if (soft_reset_in)
			revision_q <= REVISION_CODE;
		else if (write_start && addr_in == service_request_pkg::REVISION_OFFSET)
			revision_q <= data_in;
	end

	// read data and register acknowledge, captured once at access start
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			data_q <= 8'h00;
			chain_q <= 1'b0;
		end
		else if (read_start)
		begin
			chain_q <= 1'b0;
			if (addr_in == service_request_pkg::CONFIG_OFFSET)
				data_q <= {PACKAGE_TYPE, config_q[6:0]};
			else if (addr_in == service_request_pkg::REVISION_OFFSET)
				data_q <= revision_q;
			else if (reg_ack && reg_level != 2'h0)
				data_q <= modify_vector(vector_base_in, {1'b0, reg_level});
			else if (reg_ack && register_ack_chain_enable)
			begin
				data_q <= 8'h00;
				chain_q <= 1'b1;
			end
			else if (reg_ack)
				data_q <= modify_vector(vector_base_in, service_request_pkg::MOD_NONE);
			else
				data_q <= 8'h00; // zero data while register ack is off or the address is no ack address
		end
		else if (!read_active)
			chain_q <= 1'b0;
	end

	// acknowledge result from either path; hardware path stays live
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			hw_ack_q <= 1'b0;
			ack_taken_q <= 1'b0;
			ack_level_q <= service_request_pkg::LEVEL_NONE;
		end
		else
		begin
			hw_ack_q <= !acknowledge_input_n;
			ack_taken_q <= 1'b0;
			if (reg_ack && (reg_level != 2'h0 || !register_ack_chain_enable))
			begin
				ack_taken_q <= 1'b1;
				ack_level_q <= reg_level;
			end
			else if (hw_ack_start && hw_level != 2'h0)
			begin
				ack_taken_q <= 1'b1;
				ack_level_q <= hw_level;
			end
		end
	end

	assign data_out = data_q;
	assign data_oe_out = read_active && !read_start && !chain_q;
	assign acknowledge_output_n = !chain_q;
	assign ack_taken_out = ack_taken_q;
	assign ack_level_out = ack_level_q;

	pkg_bit_fixed_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		read_start && addr_in == service_request_pkg::CONFIG_OFFSET
		|=> data_out[7] == PACKAGE_TYPE)
		else $error("package type bit not fixed");
	reset_clears_cfg_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		soft_reset_in |=> config_q == 8'h00 && revision_q == REVISION_CODE)
		else $error("soft reset did not restore registers");
	revision_hold_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!soft_reset_in && !(write_start && addr_in == service_request_pkg::REVISION_OFFSET)
		|=> $stable(revision_q))
		else $error("revision register changed without write or reset");
	no_ack_disabled_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		read_start && !register_ack_enable && !hw_ack_start |=> !ack_taken_out)
		else $error("ack taken while register ack disabled");
	reg_ack_taken_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		reg_ack && reg_level != 2'h0 |=> ack_taken_out && ack_level_out == $past(reg_level))
		else $error("register ack not taken");
	vector_match_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		reg_ack && reg_level != 2'h0 |=> data_out[2:0] == {1'b0, $past(reg_level)})
		else $error("vector modification code wrong");
	chain_pass_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		reg_ack && reg_level == 2'h0 && register_ack_chain_enable
		|=> !acknowledge_output_n && !data_oe_out)
		else $error("unmatched chained ack not passed on");
	unchained_take_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		reg_ack && reg_level == 2'h0 && !register_ack_chain_enable
		|=> ack_taken_out && ack_level_out == 2'h0 && data_out[2:0] == 3'h0)
		else $error("unchained unmatched ack handled wrongly");
	fair_force_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		fairness_override |-> fair_bits_out == 3'h7)
		else $error("fairness bits not forced");
	hw_ack_live_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		hw_ack_start && hw_level != 2'h0 && !reg_ack |=> ack_taken_out)
		else $error("hardware acknowledge ignored");

	reg_ack_c: cover property (@(posedge clock_in) disable iff (!arst_n_in)
		reg_ack && reg_level != 2'h0);
	chain_c: cover property (@(posedge clock_in) disable iff (!arst_n_in)
		reg_ack && reg_level == 2'h0 && register_ack_chain_enable);
	hw_ack_c: cover property (@(posedge clock_in) disable iff (!arst_n_in)
		hw_ack_start && register_ack_enable);
endmodule : service_request_config

// >>> chain_partner.sv
/*
 * Model of the neighbouring controllers on the acknowledge chain: the
 * upstream one drives our hardware acknowledge, the downstream one counts
 * the acknowledges passed on to it.
 * Assumes one clock shared with the device.
 */
`timescale 1ns/100ps
module chain_partner (
	// clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// upstream acknowledge
	input wire logic send_in,
	output logic ack_n_out,
	// downstream acknowledge
	input wire logic pass_n_in,
	output logic [7:0] pass_count_out
);
	logic pass_n_q;
	// released line sits at its pull-up level
	assign ack_n_out = send_in ? 1'b0 : 1'b1;
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pass_n_q <= 1'b1;
			pass_count_out <= 8'h00;
		end
		else
		begin
			pass_n_q <= pass_n_in;
			// one count per falling edge, however long it stays low
			if (pass_n_q && !pass_n_in)
				pass_count_out <= pass_count_out + 8'h01;
		end
	end
endmodule : chain_partner

// >>> tb_service_request_config.sv
/*
 * Self-checking bench for the configuration and register-acknowledge block.
 * Assumes the default acknowledge addresses and revision code of the package.
 */
`timescale 1ns/100ps
module tb_service_request_config;
	logic clock_in = 1'b0, arst_n_in = 1'b0, soft_reset_in = 1'b0;
	logic select_n = 1'b1, read_n = 1'b1, write_n = 1'b1;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00, data_out, rdata;
	logic data_oe_out, roe, rtaken, rpass, acknowledge_input_n, acknowledge_output_n;
	logic [2:0] pending = 3'h0, glob = 3'h0, fair_bits_out;
	logic [1:0] hw_type = 2'h1, ack_level_out;
	logic ack_taken_out, send = 1'b0, ape, pos, gps;
	logic [7:0] pass_count;
	int miscompares = 0, n_compared = 0, n_taken = 0, t0;
	localparam logic [7:0] VB = 8'hAF;
	service_request_config dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.soft_reset_in(soft_reset_in), .select_n_in(select_n), .read_n_in(read_n),
		.write_n_in(write_n), .addr_in(addr), .data_in(wdata), .data_out(data_out),
		.data_oe_out(data_oe_out), .pending_req_in(pending), .global_req_in(glob),
		.vector_base_in(VB), .acknowledge_input_n(acknowledge_input_n),
		.hw_ack_type_in(hw_type), .acknowledge_output_n(acknowledge_output_n),
		.ack_taken_out(ack_taken_out), .ack_level_out(ack_level_out),
		.fair_bits_in(3'h5), .fair_bits_out(fair_bits_out),
		.automatic_priority_enable(ape), .priority_order_select(pos),
		.global_priority_select(gps));
	chain_partner partner (.clock_in(clock_in), .arst_n_in(arst_n_in), .send_in(send),
		.ack_n_out(acknowledge_input_n), .pass_n_in(acknowledge_output_n),
		.pass_count_out(pass_count));
	initial
	begin
		forever #12.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in)
	begin
		if (ack_taken_out === 1'b1)
			n_taken++;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock_in);
		#2;
		select_n = 1'b0;
		write_n = 1'b0;
		addr = a;
		wdata = d;
		@(posedge clock_in);
		#2;
		select_n = 1'b1;
		write_n = 1'b1;
	endtask : wr
	// extra holds stretch the strobe; the access must still count once
	task automatic rd(input logic [6:0] a, input int hold);
		@(posedge clock_in);
		#2;
		select_n = 1'b0;
		read_n = 1'b0;
		addr = a;
		t0 = n_taken;
		@(posedge clock_in);
		#2;
		rdata = data_out;
		rtaken = ack_taken_out;
		rpass = acknowledge_output_n;
		roe = data_oe_out;
		repeat (hold)
		begin
			@(posedge clock_in);
			#2;
		end
		select_n = 1'b1;
		read_n = 1'b1;
	endtask : rd
	task automatic end_of_test;
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial
	begin
		#(25 * 3000);
		miscompares++;
		end_of_test();
	end
	initial
	begin
		repeat (20) @(posedge clock_in);
		#2;
		arst_n_in = 1'b1;
		rd(service_request_pkg::CONFIG_OFFSET, 0);
		chk("config reset", rdata, 8'h00);
		chk("read oe", {7'h00, roe}, 8'h01);
		rd(service_request_pkg::REVISION_OFFSET, 0);
		chk("revision reset", rdata, service_request_pkg::REVISION_RESET);
		wr(service_request_pkg::REVISION_OFFSET, 8'hA5);
		rd(service_request_pkg::REVISION_OFFSET, 0);
		chk("revision rw", rdata, 8'hA5);
		// reserved bit written as zero by the host
		wr(service_request_pkg::CONFIG_OFFSET, 8'hFB);
		rd(service_request_pkg::CONFIG_OFFSET, 0);
		chk("config bit7", rdata, 8'h7B);
		chk("fair forced", {5'h00, fair_bits_out}, 8'h07);
		chk("prio outs", {5'h00, ape, pos, gps}, 8'h07);
		@(posedge clock_in);
		#2;
		soft_reset_in = 1'b1;
		@(posedge clock_in);
		#2;
		soft_reset_in = 1'b0;
		rd(service_request_pkg::CONFIG_OFFSET, 0);
		chk("config soft", rdata, 8'h00);
		chk("fair normal", {5'h00, fair_bits_out}, 8'h05);
		rd(service_request_pkg::REVISION_OFFSET, 0);
		chk("revision soft", rdata, service_request_pkg::REVISION_RESET);
		// read data is not looked at while register ack is off
		pending = 3'h1;
		rd(service_request_pkg::MODEM_ACK_OFFSET, 0);
		chk("no regack", {7'h00, rtaken}, 8'h00);
		wr(service_request_pkg::CONFIG_OFFSET, 8'h40);
		pending = 3'h2;
		rd(service_request_pkg::TX_ACK_OFFSET, 3);
		chk("ack take", {7'h00, rtaken}, 8'h01);
		chk("ack vector", rdata, 8'hAA);
		chk("ack level", {6'h00, ack_level_out}, 8'h02);
		chk("one take", 8'(n_taken - t0), 8'h01);
		rd(service_request_pkg::RX_ACK_OFFSET, 0);
		chk("miss vector", rdata, 8'hA8);
		chk("miss take", {7'h00, rtaken}, 8'h01);
		chk("miss level", {6'h00, ack_level_out}, 8'h00);
		wr(service_request_pkg::CONFIG_OFFSET, 8'h60);
		rd(service_request_pkg::TX_ACK_OFFSET, 0);
		chk("chain vector", rdata, 8'hAA);
		rd(service_request_pkg::RX_ACK_OFFSET, 2);
		chk("pass out", {6'h00, rpass, roe}, 8'h00);
		chk("pass take", 8'(n_taken - t0), 8'h00);
		chk("pass count", pass_count, 8'h01);
		pending = 3'h1;
		t0 = n_taken;
		@(posedge clock_in);
		#2;
		send = 1'b1;
		repeat (3) @(posedge clock_in);
		#2;
		send = 1'b0;
		repeat (2) @(posedge clock_in);
		#2;
		chk("hw take", 8'(n_taken - t0), 8'h01);
		chk("hw level", {6'h00, ack_level_out}, 8'h01);
		pending = 3'h6;
		wr(service_request_pkg::CONFIG_OFFSET, 8'h43);
		rd(service_request_pkg::MODEM_ACK_OFFSET, 0);
		chk("auto hi", rdata, 8'hAA);
		wr(service_request_pkg::CONFIG_OFFSET, 8'h42);
		rd(service_request_pkg::MODEM_ACK_OFFSET, 0);
		chk("auto lo", rdata, 8'hAB);
		// global view picks modem first, which is not pending here
		glob = 3'h7;
		wr(service_request_pkg::CONFIG_OFFSET, 8'h53);
		rd(service_request_pkg::MODEM_ACK_OFFSET, 0);
		chk("auto global", rdata, 8'hA8);
		chk("global level", {6'h00, ack_level_out}, 8'h00);
		// hardware reset in mid-run restores both registers
		wr(service_request_pkg::REVISION_OFFSET, 8'h33);
		wr(service_request_pkg::CONFIG_OFFSET, 8'h08);
		rd(service_request_pkg::REVISION_OFFSET, 0);
		chk("revision rw2", rdata, 8'h33);
		@(posedge clock_in);
		#2;
		arst_n_in = 1'b0;
		repeat (3) @(posedge clock_in);
		#2;
		arst_n_in = 1'b1;
		chk("fair hw reset", {5'h00, fair_bits_out}, 8'h05);
		rd(service_request_pkg::REVISION_OFFSET, 0);
		chk("revision hw", rdata, service_request_pkg::REVISION_RESET);
		rd(service_request_pkg::CONFIG_OFFSET, 0);
		chk("config hw", rdata, service_request_pkg::CONFIG_RESET);
		end_of_test();
	end
endmodule : tb_service_request_config
